// file: design/ltpg_top.sv
// linear trapezoid profile generator with its register slave
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module ltpg_top #(
  parameter int ADDR_W = 8  // register address width
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address channel
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // motor driver side
  output logic drive_pulse,
  output logic [1:0] profile_phase
);

  // ************************************************************
  // declarations
  // ************************************************************
  ltpg_pulse_if pif ();  // link to the pulse timer

  // bus holding registers
  logic aw_have_q;              // write address captured
  logic [7:0] aw_addr_q;        // captured write address
  logic w_have_q;               // write data captured
  logic [31:0] w_data_q;        // captured write data
  logic [3:0] w_strb_q;         // captured byte enables
  logic wr_fire;                // both halves present
  logic wr_known;               // write address is mapped
  logic [7:0] ar_addr;          // aligned read address

  // software registers
  logic [15:0] mode_q;          // profile_mode_reg
  logic [31:0] accel_q;         // accel_rate
  logic [31:0] decel_q;         // decel_rate
  logic [31:0] start_q;         // start_speed
  logic [31:0] target_q;        // target_speed
  logic [31:0] total_q;         // pulse_total
  logic [31:0] offset_q;        // signed accel counter offset

  // command strobes
  logic cmd_start;              // start a fixed pulse drive
  logic cmd_dstop;              // decelerating stop
  logic cmd_istop;              // instant stop

  // profile state
  ltpg_pkg::ltpg_phase_t phase_q;  // current profile phase
  logic stop_q;                 // decelerating stop in progress
  logic [31:0] speed_q;         // current speed
  logic [31:0] remain_q;        // pulses left
  logic [31:0] acc_pulses_q;    // pulses spent accelerating
  logic [31:0] ramp_acc_q;      // rate step accumulator

  // profile arithmetic
  logic [31:0] dec_rate;        // rate used while decelerating
  logic [31:0] ramp_rate;       // rate of the active ramp
  logic [32:0] ramp_sum;        // accumulator plus rate
  logic [32:0] ramp_wrap;       // sum less one second
  logic ramp_step;              // one speed unit is due
  logic signed [33:0] eff_rem;  // remaining pulses less offset
  logic [65:0] need_lhs;        // remaining times twice decel rate
  logic [65:0] need_rhs;        // speed squared less start squared
  logic [65:0] tri_lhs;         // twice accel pulses times rate sum
  logic [65:0] tri_rhs;         // total times decel rate
  logic auto_decel;             // automatic deceleration due
  logic tri_hold;               // triangle prevention trips
  logic last_pulse;             // final pulse of the drive

  // ************************************************************
  // register bus: write path
  // ************************************************************
  // merge new data into a word under byte enables
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  // capture the write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  // capture the write data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  // decode which write addresses exist
  always_comb begin
    case (aw_addr_q)
      ltpg_pkg::OFF_MODE, ltpg_pkg::OFF_ACCEL, ltpg_pkg::OFF_DECEL,
      ltpg_pkg::OFF_START, ltpg_pkg::OFF_TARGET, ltpg_pkg::OFF_TOTAL,
      ltpg_pkg::OFF_OFFSET, ltpg_pkg::OFF_CMD, ltpg_pkg::OFF_STATUS,
      ltpg_pkg::OFF_SPEED, ltpg_pkg::OFF_REMAIN: wr_known = 1'b1;
      default: wr_known = 1'b0;  // unmapped
    endcase
  end

  // write response, held until the master takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ltpg_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? ltpg_pkg::RESP_OKAY : ltpg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= ltpg_pkg::MODE_RST;
      accel_q <= ltpg_pkg::PARAM_RST;
      decel_q <= ltpg_pkg::PARAM_RST;
      start_q <= ltpg_pkg::PARAM_RST;
      target_q <= ltpg_pkg::PARAM_RST;
      total_q <= ltpg_pkg::PARAM_RST;
      offset_q <= ltpg_pkg::OFFSET_RST;
    end else if (wr_fire) begin
      case (aw_addr_q)
        ltpg_pkg::OFF_MODE: begin
          mode_q <= 16'(lane_merge({16'h0000, mode_q}, w_data_q, w_strb_q));
        end
        ltpg_pkg::OFF_ACCEL: accel_q <= lane_merge(accel_q, w_data_q, w_strb_q);
        ltpg_pkg::OFF_DECEL: decel_q <= lane_merge(decel_q, w_data_q, w_strb_q);
        ltpg_pkg::OFF_START: start_q <= lane_merge(start_q, w_data_q, w_strb_q);
        ltpg_pkg::OFF_TARGET: target_q <= lane_merge(target_q, w_data_q, w_strb_q);
        ltpg_pkg::OFF_TOTAL: total_q <= lane_merge(total_q, w_data_q, w_strb_q);
        ltpg_pkg::OFF_OFFSET: offset_q <= lane_merge(offset_q, w_data_q, w_strb_q);
        default: ;  // commands and read-only words store nothing
      endcase
    end
  end

  // command strobes, low byte only
  assign cmd_start = wr_fire && (aw_addr_q == ltpg_pkg::OFF_CMD) && w_strb_q[0]
                     && w_data_q[ltpg_pkg::CMD_START_BIT];
  assign cmd_dstop = wr_fire && (aw_addr_q == ltpg_pkg::OFF_CMD) && w_strb_q[0]
                     && w_data_q[ltpg_pkg::CMD_DSTOP_BIT];
  assign cmd_istop = wr_fire && (aw_addr_q == ltpg_pkg::OFF_CMD) && w_strb_q[0]
                     && w_data_q[ltpg_pkg::CMD_ISTOP_BIT];

  // ************************************************************
  // register bus: read path
  // ************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_addr = {s_axi_araddr[7:2], 2'b00};

  // read data, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ltpg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ltpg_pkg::RESP_OKAY;
      case (ar_addr)
        ltpg_pkg::OFF_MODE: s_axi_rdata <= {16'h0000, mode_q};
        ltpg_pkg::OFF_ACCEL: s_axi_rdata <= accel_q;
        ltpg_pkg::OFF_DECEL: s_axi_rdata <= decel_q;
        ltpg_pkg::OFF_START: s_axi_rdata <= start_q;
        ltpg_pkg::OFF_TARGET: s_axi_rdata <= target_q;
        ltpg_pkg::OFF_TOTAL: s_axi_rdata <= total_q;
        ltpg_pkg::OFF_OFFSET: s_axi_rdata <= offset_q;
        ltpg_pkg::OFF_CMD: s_axi_rdata <= 32'h0000_0000;  // strobes read zero
        ltpg_pkg::OFF_STATUS: s_axi_rdata <= {28'h0000000, stop_q, 1'b0, phase_q};
        ltpg_pkg::OFF_SPEED: s_axi_rdata <= speed_q;
        ltpg_pkg::OFF_REMAIN: s_axi_rdata <= remain_q;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= ltpg_pkg::RESP_SLVERR;  // unmapped
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // profile arithmetic
  // ************************************************************
  // separate rate only when the select bit is set
  assign dec_rate = mode_q[ltpg_pkg::SEPARATE_BIT] ? decel_q : accel_q;
  assign ramp_rate = (phase_q == ltpg_pkg::PH_DECEL) ? dec_rate : accel_q;

  // rate accumulator: one speed unit per clock-rate worth of rate
  assign ramp_sum = {1'b0, ramp_acc_q} + {1'b0, ramp_rate};
  assign ramp_wrap = ramp_sum - {1'b0, ltpg_pkg::CLK_HZ};
  assign ramp_step = ramp_sum >= {1'b0, ltpg_pkg::CLK_HZ};

  // negative offset makes the remainder look longer, so decel starts later
  assign eff_rem = $signed({2'b00, remain_q}) - $signed({{2{offset_q[31]}}, offset_q});

  // pulses needed to ramp down: (v^2 - sv^2) / (2 * rate)
  assign need_lhs = 66'({eff_rem[32:0], 1'b0}) * 66'(dec_rate);
  assign need_rhs = 66'(speed_q) * 66'(speed_q) - 66'(start_q) * 66'(start_q);

  // accel plus projected decel pulses against half the total
  assign tri_lhs = 66'({acc_pulses_q, 1'b0}) * 66'({1'b0, accel_q} + {1'b0, dec_rate});
  assign tri_rhs = 66'(total_q) * 66'(dec_rate);

  // decide automatic deceleration
  always_comb begin
    if (mode_q[ltpg_pkg::MANUAL_BIT] || stop_q) begin
      auto_decel = 1'b0;  // no automatic point in manual mode
    end else if (eff_rem <= 34'sd0) begin
      auto_decel = 1'b1;
    end else if (!mode_q[ltpg_pkg::SEPARATE_BIT]) begin
      auto_decel = eff_rem < $signed({2'b00, acc_pulses_q});
    end else begin
      auto_decel = need_lhs <= need_rhs;
    end
  end

  // triangle prevention is on unless bit 13 or the manual bit is set
  assign tri_hold = !mode_q[ltpg_pkg::TRI_OFF_BIT] && !mode_q[ltpg_pkg::MANUAL_BIT]
                    && (tri_lhs > tri_rhs);

  assign last_pulse = pif.pulse && (remain_q == 32'h0000_0001);

  // ************************************************************
  // profile sequencer
  // ************************************************************
  // phase transitions; instant stop and the last pulse win
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= ltpg_pkg::PH_IDLE;
      stop_q <= 1'b0;
    end else begin
      case (phase_q)
        ltpg_pkg::PH_IDLE: begin
          stop_q <= 1'b0;
          if (cmd_start && (total_q != 32'h0000_0000)) begin
            phase_q <= ltpg_pkg::PH_ACCEL;
          end
        end
        ltpg_pkg::PH_ACCEL: begin
          if (cmd_istop || last_pulse) begin
            phase_q <= ltpg_pkg::PH_IDLE;
          end else if (cmd_dstop) begin
            phase_q <= ltpg_pkg::PH_DECEL;
            stop_q <= 1'b1;
          end else if (auto_decel) begin
            phase_q <= ltpg_pkg::PH_DECEL;
          end else if (tri_hold || (speed_q >= target_q)) begin
            phase_q <= ltpg_pkg::PH_HOLD;
          end
        end
        ltpg_pkg::PH_HOLD: begin
          if (cmd_istop || last_pulse) begin
            phase_q <= ltpg_pkg::PH_IDLE;
          end else if (cmd_dstop) begin
            phase_q <= ltpg_pkg::PH_DECEL;
            stop_q <= 1'b1;
          end else if (auto_decel) begin
            phase_q <= ltpg_pkg::PH_DECEL;
          end
        end
        ltpg_pkg::PH_DECEL: begin
          if (cmd_istop || last_pulse) begin
            phase_q <= ltpg_pkg::PH_IDLE;
          end else if (stop_q && (speed_q <= start_q)) begin
            phase_q <= ltpg_pkg::PH_IDLE;  // stop ends at start speed
          end else if (cmd_dstop) begin
            stop_q <= 1'b1;
          end
        end
        default: phase_q <= ltpg_pkg::PH_IDLE;
      endcase
    end
  end

  // current speed, stepped once per rate step
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_q <= 32'h0000_0000;
      ramp_acc_q <= 32'h0000_0000;
    end else if (phase_q == ltpg_pkg::PH_IDLE) begin
      speed_q <= start_q;
      ramp_acc_q <= 32'h0000_0000;
    end else if (phase_q == ltpg_pkg::PH_ACCEL) begin
      ramp_acc_q <= ramp_step ? ramp_wrap[31:0] : ramp_sum[31:0];
      if (ramp_step && (speed_q < target_q)) begin
        speed_q <= speed_q + 32'h0000_0001;
      end
    end else if (phase_q == ltpg_pkg::PH_DECEL) begin
      ramp_acc_q <= ramp_step ? ramp_wrap[31:0] : ramp_sum[31:0];
      if (ramp_step && (speed_q > start_q)) begin
        speed_q <= speed_q - 32'h0000_0001;
      end
    end else begin
      ramp_acc_q <= 32'h0000_0000;  // hold keeps speed
    end
  end

  // pulse bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remain_q <= 32'h0000_0000;
      acc_pulses_q <= 32'h0000_0000;
    end else if (phase_q == ltpg_pkg::PH_IDLE) begin
      if (cmd_start) begin
        remain_q <= total_q;
        acc_pulses_q <= 32'h0000_0000;
      end
    end else if (pif.pulse) begin
      remain_q <= remain_q - 32'h0000_0001;
      if (phase_q == ltpg_pkg::PH_ACCEL) begin
        acc_pulses_q <= acc_pulses_q + 32'h0000_0001;
      end
    end
  end

  // ************************************************************
  // pulse timer and outputs
  // ************************************************************
  assign pif.run = (phase_q != ltpg_pkg::PH_IDLE);
  assign pif.speed = speed_q;

  ltpg_pulse_gen u_pulse (
    .aclk(aclk),
    .aresetn(aresetn),
    .pif(pif)
  );

  assign drive_pulse = pif.pulse;
  assign profile_phase = phase_q;

endmodule

// file: design/ltpg_pkg.sv
// shared constants and types for the linear trapezoid profile generator
// What this block does
// - linear ramp from start speed to target speed
// - symmetric: decelerate when remaining below accel count
// - symmetric decel same slope, end after all pulses
// - decelerating stop during accel decelerates at once
// - two mode bits pick decel, rate; curve bit has no effect
// - select bit clear: accel rate governs decel
// - select bit set: separate decel rate used
// - triangle prevention holds speed past half total
// - triangle prevention on at reset, bit13 disables
// - decel stop overrides triangle prevention immediately
// - non-symmetric decel point computed from rates
// - triangle prevention also in non-symmetric mode
// - accel counter offset resets to zero
package ltpg_pkg;

  // ************************************************************
  // clock and rate scaling
  // ************************************************************
  localparam logic [31:0] CLK_HZ = 32'h0ee6b280;  // 250 MHz system clock

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_MODE = 8'h00;    // profile_mode_reg
  localparam logic [7:0] OFF_ACCEL = 8'h04;   // accel_rate, pps/s
  localparam logic [7:0] OFF_DECEL = 8'h08;   // decel_rate, pps/s
  localparam logic [7:0] OFF_START = 8'h0c;   // start_speed, pps
  localparam logic [7:0] OFF_TARGET = 8'h10;  // target_speed, pps
  localparam logic [7:0] OFF_TOTAL = 8'h14;   // pulse_total
  localparam logic [7:0] OFF_OFFSET = 8'h18;  // signed accel counter offset
  localparam logic [7:0] OFF_CMD = 8'h1c;     // command strobes
  localparam logic [7:0] OFF_STATUS = 8'h20;  // phase and flags
  localparam logic [7:0] OFF_SPEED = 8'h24;   // current speed
  localparam logic [7:0] OFF_REMAIN = 8'h28;  // pulses still to emit

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int MANUAL_BIT = 0;    // manual_decel_select
  localparam int SEPARATE_BIT = 1;  // separate_decel_select
  localparam int SCURVE_BIT = 2;    // scurve_select
  localparam int TRI_OFF_BIT = 13;  // triangle prevention disable
  localparam int CMD_START_BIT = 0;  // start fixed pulse drive
  localparam int CMD_DSTOP_BIT = 1;  // decelerating stop
  localparam int CMD_ISTOP_BIT = 2;  // instant stop

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [31:0] PARAM_RST = 32'h0000_0000;
  localparam logic [31:0] OFFSET_RST = 32'h0000_0000;

  // ************************************************************
  // bus responses and profile phases
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ACCEL = 2'b01,
    PH_HOLD = 2'b10,
    PH_DECEL = 2'b11
  } ltpg_phase_t;

endpackage

// file: design/ltpg_pulse_if.sv
// carrier between profile control and the drive pulse timer
`timescale 1ns/1ps
interface ltpg_pulse_if;
  logic run;           // timer enabled while a drive is active
  logic [31:0] speed;  // current speed in pulses per second
  logic pulse;         // one-cycle drive pulse strobe

  modport gen (input run, input speed, output pulse);
  modport ctl (output run, output speed, input pulse);
endinterface

// file: design/ltpg_pulse_gen.sv
// drive pulse timer: phase accumulator paced by the current speed
`timescale 1ns/1ps
module ltpg_pulse_gen (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // speed in, pulse out
  ltpg_pulse_if.gen pif
);

  logic [31:0] phase_q;  // fractional pulse phase
  logic [32:0] sum_d;    // phase plus speed
  logic [32:0] wrap_d;   // sum less one full second

  assign sum_d = {1'b0, phase_q} + {1'b0, pif.speed};
  assign wrap_d = sum_d - {1'b0, ltpg_pkg::CLK_HZ};

  // one pulse each time the phase passes the clock rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_q <= 32'h0000_0000;
      pif.pulse <= 1'b0;
    end else if (!pif.run) begin
      phase_q <= 32'h0000_0000;  // restart phase for each drive
      pif.pulse <= 1'b0;
    end else if (sum_d >= {1'b0, ltpg_pkg::CLK_HZ}) begin
      phase_q <= wrap_d[31:0];
      pif.pulse <= 1'b1;
    end else begin
      phase_q <= sum_d[31:0];
      pif.pulse <= 1'b0;
    end
  end

endmodule

// file: verification/ltpg_motor_model.sv
// motor driver stand-in that counts the drive pulses it receives
`timescale 1ns/1ps
module ltpg_motor_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pulses in, step count out
  input wire logic drive_pulse,
  input wire logic count_clr,
  output logic [31:0] pulse_count
);
  // ********
  // step counter
  // ********
  // one step per strobe, like a driver position counter
  always_ff @(posedge aclk) begin
    if (!aresetn || count_clr) begin
      pulse_count <= 32'h0000_0000;
    end else if (drive_pulse) begin
      pulse_count <= pulse_count + 32'h0000_0001;
    end
  end
endmodule

// file: verification/ltpg_top_assertions.sv
// port checker for the profile generator
`timescale 1ns/1ps
module ltpg_top_chk #(
  parameter int ADDR_W = 8  // register address width
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // drive side
  input wire logic drive_pulse,
  input wire logic [1:0] profile_phase
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_start_accel: assert property (
    $past(profile_phase) == ltpg_pkg::PH_IDLE && profile_phase != ltpg_pkg::PH_IDLE
    |-> profile_phase == ltpg_pkg::PH_ACCEL) else $error("drive did not start in accel");
  a_hold_flat: assert property (
    profile_phase == ltpg_pkg::PH_HOLD |=> profile_phase != ltpg_pkg::PH_ACCEL)
    else $error("hold went back to accel");
  a_decel_down: assert property (
    profile_phase == ltpg_pkg::PH_DECEL |=> profile_phase inside {ltpg_pkg::PH_DECEL,
    ltpg_pkg::PH_IDLE}) else $error("decel left for a ramp phase");
  a_idle_quiet: assert property (
    profile_phase == ltpg_pkg::PH_IDLE [*2] |-> !drive_pulse)
    else $error("pulse while idle");
  a_dstop_decel: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
    && s_axi_awaddr == ltpg_pkg::OFF_CMD && s_axi_wdata[1]
    && profile_phase == ltpg_pkg::PH_ACCEL |-> ##2 profile_phase == ltpg_pkg::PH_DECEL)
    else $error("stop did not decelerate at once");
endmodule
bind ltpg_top ltpg_top_chk #(.ADDR_W(ADDR_W)) i_ltpg_top_chk (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .drive_pulse, .profile_phase);

// file: verification/testbench.sv
// self-checking bench: register access and drive profiles
`timescale 1ns/1ps
module testbench;
  // ********
  // signals
  // ********
  typedef struct {
    logic [31:0] mode;
    logic [31:0] acc;
    logic [31:0] dec;
    logic [3:0] seen;
  } ltpg_row_t;
  localparam logic [1:0] OK = ltpg_pkg::RESP_OKAY;
  localparam logic [31:0] TOT = 32'h3c;  // pulses per row drive
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b1;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b1;
  logic cnt_clr = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, drive_pulse;
  logic [1:0] bresp, rresp, phase;
  logic [31:0] rdata, pulse_count;
  logic [3:0] seen;
  int bad_count = 0;
  int total_checks = 0;
  ltpg_row_t rows [6];
  always #2 aclk = ~aclk;  // 250 MHz
  ltpg_top i_ltpg_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_pulse(drive_pulse),
    .profile_phase(phase));
  ltpg_motor_model i_ltpg_motor_model (.aclk(aclk), .aresetn(aresetn),
    .drive_pulse(drive_pulse), .count_clr(cnt_clr), .pulse_count(pulse_count));
  // ********
  // tasks
  // ********
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // a wait that ran out ends the run
  task automatic tmo(input logic hit);
    if (hit) begin
      bad_count++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask
  // bus write, each half released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    tmo(n >= 40);
    check({30'h0, bresp}, {30'h0, er});
  endtask
  // bus read against an expected word
  task automatic rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    tmo(n >= 40);
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
  endtask
  // follow a drive to its end, noting each phase
  task automatic wait_idle();
    int n;
    n = 0;
    seen = 4'h0;
    do begin
      @(posedge aclk);
      n++;
      seen[phase] = 1'b1;
    end while (phase != ltpg_pkg::PH_IDLE && n < 20000);
    tmo(n >= 20000);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ********
  // sequence
  // ********
  initial begin
    rows[0] = '{32'h0, 32'hee6b280, 32'h1, 4'hf};  // symmetric
    rows[1] = '{32'h2, 32'h7735940, 32'hee6b280, 4'hf};
    rows[2] = '{32'h2000, 32'hee6b280, 32'h1, 4'hb};  // no hold
    rows[3] = '{32'h2002, 32'h7735940, 32'hee6b280, 4'hb};
    rows[4] = '{32'h4, 32'hee6b280, 32'h1, 4'hf};  // curve bit
    rows[5] = '{32'h1, 32'hee6b280, 32'h1, 4'h3};  // manual
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(ltpg_pkg::OFF_MODE, 32'h0, OK);
    rdchk(ltpg_pkg::OFF_OFFSET, 32'h0, OK);
    rdchk(8'h3c, 32'h0, ltpg_pkg::RESP_SLVERR);
    wr(8'h3c, 32'h1, ltpg_pkg::RESP_SLVERR);
    wr(ltpg_pkg::OFF_START, 32'h0026_25a0, OK);
    wr(ltpg_pkg::OFF_TARGET, 32'h0026_4cb0, OK);
    wr(ltpg_pkg::OFF_TOTAL, TOT, OK);
    for (int i = 0; i < 6; i++) begin
      wr(ltpg_pkg::OFF_MODE, rows[i].mode, OK);
      rdchk(ltpg_pkg::OFF_MODE, rows[i].mode, OK);
      cnt_clr <= 1'b1;
      wr(ltpg_pkg::OFF_ACCEL, rows[i].acc, OK);
      cnt_clr <= 1'b0;
      wr(ltpg_pkg::OFF_DECEL, rows[i].dec, OK);
      wr(ltpg_pkg::OFF_CMD, 32'h1, OK);
      wait_idle();
      check({28'h0, seen}, {28'h0, rows[i].seen});
      check(pulse_count, TOT);
      rdchk(ltpg_pkg::OFF_REMAIN, 32'h0, OK);
    end
    // decelerating stop early in the ramp
    wr(ltpg_pkg::OFF_MODE, 32'h0, OK);
    wr(ltpg_pkg::OFF_TOTAL, 32'h7d0, OK);
    cnt_clr <= 1'b1;
    wr(ltpg_pkg::OFF_CMD, 32'h1, OK);
    cnt_clr <= 1'b0;
    wr(ltpg_pkg::OFF_CMD, 32'h2, OK);
    check({30'h0, phase}, {30'h0, ltpg_pkg::PH_DECEL});
    wait_idle();
    check({28'h0, seen}, 32'h9);
    check({31'h0, pulse_count < 32'h7d0}, 32'h1);
    // instant stop
    wr(ltpg_pkg::OFF_CMD, 32'h1, OK);
    wr(ltpg_pkg::OFF_CMD, 32'h4, OK);
    check({30'h0, phase}, {30'h0, ltpg_pkg::PH_IDLE});
    // reset in mid drive clears mode and offset
    wr(ltpg_pkg::OFF_MODE, 32'h2000, OK);
    wr(ltpg_pkg::OFF_OFFSET, 32'hffff_fffe, OK);
    wr(ltpg_pkg::OFF_CMD, 32'h1, OK);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({30'h0, phase}, {30'h0, ltpg_pkg::PH_IDLE});
    rdchk(ltpg_pkg::OFF_MODE, 32'h0, OK);
    rdchk(ltpg_pkg::OFF_OFFSET, 32'h0, OK);
    report_and_stop();
  end
endmodule
